// ===== hdl/sdr_map.svh
// constants for the two bank synchronous dram command core
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// pin and column widths
`define SDR_ADDR_W 12
`define SDR_DQ_W 16
`define SDR_COL_W 8
// address fields of a command
`define SDR_A_BANK 11
`define SDR_A_AUTOPRE 10
`define SDR_A_COL 7:0
// operating mode word fields
`define SDR_F_WMODE 11:9
`define SDR_F_LAT 6:4
`define SDR_F_BTYPE 3
`define SDR_F_BLEN 2:0
// operating mode word after reset
`define SDR_MODE_RST 12'h020
// write mode codes
`define SDR_WM_BURST 3'h0
`define SDR_WM_SINGLE 3'h1
// burst length codes
`define SDR_BL_1 3'h0
`define SDR_BL_2 3'h1
`define SDR_BL_4 3'h2
`define SDR_BL_8 3'h3
`define SDR_BL_PAGE 3'h7
// read latency codes
`define SDR_LAT_2 3'h2
`define SDR_LAT_3 3'h3
// access stream word: write flag, bank, column, data, byte masks
`define SDR_ACC_W 28
`define SDR_ACC_DEPTH 8

`endif

// ===== hdl/sdr_pkg.sv
// types shared by the dram command core
package sdr_pkg;

    // per bank state, one-hot
    typedef enum logic [5:0] {
        SDR_B_IDLE = 6'h01,
        SDR_B_ACT  = 6'h02,
        SDR_B_RD   = 6'h04,
        SDR_B_WR   = 6'h08,
        SDR_B_RDP  = 6'h10,
        SDR_B_WRP  = 6'h20
    } sdr_bank_t;

    // power state, one-hot
    typedef enum logic [2:0] {
        SDR_P_RUN  = 3'h1,
        SDR_P_DOWN = 3'h2,
        SDR_P_SELF = 3'h4
    } sdr_pwr_t;

    // decoded command
    typedef enum logic [3:0] {
        SDR_C_DESEL = 4'h0,
        SDR_C_NOP   = 4'h1,
        SDR_C_STOP  = 4'h2,
        SDR_C_READ  = 4'h3,
        SDR_C_WRITE = 4'h4,
        SDR_C_ACT   = 4'h5,
        SDR_C_PRE   = 4'h6,
        SDR_C_REF   = 4'h7,
        SDR_C_MODE  = 4'h8
    } sdr_cmd_t;

endpackage

// ===== hdl/sdr_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module sdr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // first stage feeds only the second
    always_comb begin
        nxt_meta = d_i;
        nxt_q = meta_ff;
        if (rst_i) begin
            nxt_meta = '0;
            nxt_q = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        meta_ff <= nxt_meta;
        q_ff <= nxt_q;
    end

    assign q_o = q_ff;
endmodule

`default_nettype wire

// ===== hdl/sdr_fifo.sv
// access stream fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module sdr_fifo #(
    parameter int W = 28,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // pointer and level update
    always_comb begin
        push = in_valid_i && (cnt_ff != (AW+1)'(D)); // full refuses
        pop = out_ready_i && (cnt_ff != '0);
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (rst_i) begin
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        wp_ff <= nxt_wp;
        rp_ff <= nxt_rp;
        cnt_ff <= nxt_cnt;
        if (push) begin
            mem[wp_ff] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt_ff != (AW+1)'(D));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem[rp_ff];
endmodule

`default_nettype wire

// ===== hdl/sdr_core.sv
// command core of a two bank synchronous dram
// Notes on behaviour
// - rising clock enable wakes the device without waiting for a link edge
// - read and write take column from low bits; address bits 8 and 9 ignored
// - each bank tracked separately; next state from command and bank bit
// - activate on idle bank latches row, bit 11 picks bank, goes active
// - read with bit 10 high closes bank after burst; low keeps it active
// - write with bit 10 high closes bank after burst; low keeps it active
// - mode load takes address 11..0: options, latency, type, length
// - first read word appears after the programmed read latency
// - burst starts at the given column; following columns made inside
// - burst lengths one, two, four, eight words or full page
// - burst order sequential or interleaved by the burst type bit
// - write mode code zero gives write bursts of programmed length
// - write burst starts on the command cycle with its own column and bank
// - write mode code one writes single column; reads keep burst length
// - commands, address and masks sampled on the rising link clock edge
// - clock enable low with banks idle enters power down, or self refresh on a refresh command, inputs ignored
`timescale 1ns/10ps
`default_nettype none
`include "sdr_map.svh"

module sdr_core (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic sd_clk_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [`SDR_ADDR_W-1:0] addr_i,
    input wire logic low_byte_mask_i,
    input wire logic high_byte_mask_i,
    input wire logic [`SDR_DQ_W-1:0] dq_i,
    output logic [`SDR_DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [`SDR_DQ_W-1:0] rdat_i,
    output logic acc_valid_o,
    input wire logic acc_ready_i,
    output logic [`SDR_ACC_W-1:0] acc_data_o,
    output logic [5:0] bank0_state_o,
    output logic [5:0] bank1_state_o,
    output logic [`SDR_ADDR_W-1:0] mode_word_o,
    output logic power_down_o,
    output logic self_refresh_o,
    output logic overflow_o
);
    localparam int SW = 36;
    logic [SW-1:0] pins_s;
    logic clk_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, lm_s, hm_s;
    logic [`SDR_ADDR_W-1:0] addr_s;
    logic [`SDR_DQ_W-1:0] dq_s;

    // every pin passes two flip-flops before use
    sdr_sync #(.W(SW)) u_sync (
        .clk_i(core_clk_i),
        .rst_i(reset_i),
        .d_i({sd_clk_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i,
              low_byte_mask_i, high_byte_mask_i, dq_i}),
        .q_o(pins_s)
    );
    assign {clk_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s,
            lm_s, hm_s, dq_s} = pins_s;

    // command decode from select and strobes
    function automatic sdr_pkg::sdr_cmd_t decode(input logic cs_n,
        input logic ras_n, input logic cas_n, input logic we_n);
        if (cs_n) begin
            return sdr_pkg::SDR_C_DESEL;
        end
        unique case ({ras_n, cas_n, we_n})
            3'h7: return sdr_pkg::SDR_C_NOP;
            3'h6: return sdr_pkg::SDR_C_STOP;
            3'h5: return sdr_pkg::SDR_C_READ;
            3'h4: return sdr_pkg::SDR_C_WRITE;
            3'h3: return sdr_pkg::SDR_C_ACT;
            3'h2: return sdr_pkg::SDR_C_PRE;
            3'h1: return sdr_pkg::SDR_C_REF;
            3'h0: return sdr_pkg::SDR_C_MODE;
        endcase
    endfunction

    // burst length in words; reserved codes give one word
    function automatic logic [8:0] burst_len(input logic [2:0] code);
        unique case (code)
            `SDR_BL_2: return 9'h002;
            `SDR_BL_4: return 9'h004;
            `SDR_BL_8: return 9'h008;
            `SDR_BL_PAGE: return 9'h100;
            default: return 9'h001;
        endcase
    endfunction

    // column of beat idx: wrap inside the burst block
    function automatic logic [7:0] burst_col(input logic [7:0] start,
        input logic [7:0] idx, input logic [8:0] len, input logic ilv);
        logic [7:0] msk;
        logic [7:0] off;
        msk = 8'(len - 9'h001);
        off = ilv ? ((start ^ idx) & msk) : (8'(start + idx) & msk);
        return (start & ~msk) | off;
    endfunction

    // bank state once its burst is over
    function automatic sdr_pkg::sdr_bank_t finish(input sdr_pkg::sdr_bank_t b);
        if (b == sdr_pkg::SDR_B_RDP || b == sdr_pkg::SDR_B_WRP) begin
            return sdr_pkg::SDR_B_IDLE;
        end
        if (b == sdr_pkg::SDR_B_RD || b == sdr_pkg::SDR_B_WR) begin
            return sdr_pkg::SDR_B_ACT;
        end
        return b;
    endfunction

    sdr_pkg::sdr_pwr_t pwr_ff, nxt_pwr;
    sdr_pkg::sdr_bank_t bank_ff [2];
    sdr_pkg::sdr_bank_t nxt_bank [2];
    sdr_pkg::sdr_cmd_t cmd;
    logic [`SDR_ADDR_W-1:0] mode_ff, nxt_mode;
    logic [`SDR_ADDR_W-2:0] row_ff [2];
    logic [`SDR_ADDR_W-2:0] nxt_row [2];
    logic clk_d_ff, le, run, bsel, both_idle, act_ok;
    logic bst_ff, nxt_bst, bwr_ff, nxt_bwr, bbank_ff, nxt_bbank;
    logic [7:0] bstart_ff, nxt_bstart;
    logic [8:0] bidx_ff, nxt_bidx, blen_ff, nxt_blen, len_rd;
    logic [3:0] pipe_ff, nxt_pipe;
    logic dq_oe_ff, nxt_dq_oe, ovf_ff, nxt_ovf;
    logic [`SDR_DQ_W-1:0] dq_ff, nxt_dq;
    logic beat, beat_wr, beat_bank, rd_go, wr_go, push, fifo_rdy;
    logic [7:0] beat_col;
    logic [1:0] lat_idx;

    // rising link clock edge seen from the synchronised copy
    assign le = clk_s && !clk_d_ff;
    assign run = (pwr_ff == sdr_pkg::SDR_P_RUN) && cke_s;
    assign cmd = decode(cs_n_s, ras_n_s, cas_n_s, we_n_s);
    assign bsel = addr_s[`SDR_A_BANK];
    assign both_idle = (bank_ff[0] == sdr_pkg::SDR_B_IDLE) &&
                       (bank_ff[1] == sdr_pkg::SDR_B_IDLE) && !bst_ff;
    assign act_ok = bank_ff[bsel] != sdr_pkg::SDR_B_IDLE;
    assign rd_go = le && run && (cmd == sdr_pkg::SDR_C_READ) && act_ok;
    assign wr_go = le && run && (cmd == sdr_pkg::SDR_C_WRITE) && act_ok;
    assign len_rd = burst_len(mode_ff[`SDR_F_BLEN]);
    assign lat_idx = (mode_ff[`SDR_F_LAT] == `SDR_LAT_2) ? 2'h1 : 2'h2;

    // burst, bank, power and mode state
    always_comb begin
        nxt_pwr = pwr_ff;
        nxt_bank = bank_ff;
        nxt_row = row_ff;
        nxt_mode = mode_ff;
        nxt_bst = bst_ff;
        nxt_bwr = bwr_ff;
        nxt_bbank = bbank_ff;
        nxt_bstart = bstart_ff;
        nxt_bidx = bidx_ff;
        nxt_blen = blen_ff;
        beat = 1'b0;
        beat_wr = bwr_ff;
        beat_bank = bbank_ff;
        beat_col = burst_col(bstart_ff, bidx_ff[7:0], blen_ff,
                             mode_ff[`SDR_F_BTYPE]);
        if (pwr_ff != sdr_pkg::SDR_P_RUN) begin
            // wake without a link edge; other inputs ignored meanwhile
            if (cke_s) begin
                nxt_pwr = sdr_pkg::SDR_P_RUN;
            end
        end else if (le && !cke_s) begin
            // clock enable low: sleep when idle, else suspend
            if (both_idle) begin
                nxt_pwr = (cmd == sdr_pkg::SDR_C_REF) ?
                          sdr_pkg::SDR_P_SELF : sdr_pkg::SDR_P_DOWN;
            end
        end else if (le) begin
            // running burst emits its next beat
            if (bst_ff) begin
                beat = 1'b1;
                nxt_bidx = bidx_ff + 9'h001;
                if (blen_ff == 9'h100) begin
                    nxt_bidx = {1'b0, nxt_bidx[7:0]};
                end else if (nxt_bidx == blen_ff) begin
                    nxt_bst = 1'b0;
                    nxt_bank[bbank_ff] = finish(bank_ff[bbank_ff]);
                end
            end
            unique case (cmd)
                sdr_pkg::SDR_C_READ, sdr_pkg::SDR_C_WRITE: begin
                    if (act_ok) begin
                        if (bst_ff && bbank_ff != bsel) begin
                            nxt_bank[bbank_ff] = finish(bank_ff[bbank_ff]);
                        end
                        nxt_bwr = (cmd == sdr_pkg::SDR_C_WRITE);
                        nxt_bbank = bsel;
                        nxt_bstart = addr_s[`SDR_A_COL];
                        nxt_blen = len_rd;
                        if (nxt_bwr &&
                            mode_ff[`SDR_F_WMODE] == `SDR_WM_SINGLE) begin
                            nxt_blen = 9'h001;
                        end
                        // first beat on the command edge itself
                        beat = 1'b1;
                        beat_wr = nxt_bwr;
                        beat_bank = bsel;
                        beat_col = addr_s[`SDR_A_COL];
                        nxt_bidx = 9'h001;
                        nxt_bst = (nxt_blen != 9'h001);
                        if (addr_s[`SDR_A_AUTOPRE]) begin
                            nxt_bank[bsel] = nxt_bwr ? sdr_pkg::SDR_B_WRP :
                                             sdr_pkg::SDR_B_RDP;
                        end else begin
                            nxt_bank[bsel] = nxt_bwr ? sdr_pkg::SDR_B_WR :
                                             sdr_pkg::SDR_B_RD;
                        end
                        if (!nxt_bst) begin
                            nxt_bank[bsel] = finish(nxt_bank[bsel]);
                        end
                    end
                end
                sdr_pkg::SDR_C_STOP: begin
                    if (bst_ff) begin
                        nxt_bst = 1'b0;
                        nxt_bank[bbank_ff] = finish(bank_ff[bbank_ff]);
                    end
                end
                sdr_pkg::SDR_C_ACT: begin
                    if (bank_ff[bsel] == sdr_pkg::SDR_B_IDLE) begin
                        nxt_bank[bsel] = sdr_pkg::SDR_B_ACT;
                        nxt_row[bsel] = addr_s[`SDR_A_BANK-1:0];
                    end
                end
                sdr_pkg::SDR_C_PRE: begin
                    for (int b = 0; b < 2; b++) begin
                        if (addr_s[`SDR_A_AUTOPRE] || bsel == b[0]) begin
                            nxt_bank[b] = sdr_pkg::SDR_B_IDLE;
                            if (bbank_ff == b[0]) begin
                                nxt_bst = 1'b0;
                            end
                        end
                    end
                end
                sdr_pkg::SDR_C_MODE: begin
                    if (both_idle) begin
                        nxt_mode = addr_s;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reset_i) begin
            nxt_pwr = sdr_pkg::SDR_P_RUN;
            nxt_bank[0] = sdr_pkg::SDR_B_IDLE;
            nxt_bank[1] = sdr_pkg::SDR_B_IDLE;
            nxt_mode = `SDR_MODE_RST;
            nxt_bst = 1'b0;
            nxt_bwr = 1'b0;
            nxt_bbank = 1'b0;
            nxt_bidx = '0;
            nxt_blen = 9'h001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        pwr_ff <= nxt_pwr;
        bank_ff <= nxt_bank;
        row_ff <= nxt_row;
        mode_ff <= nxt_mode;
        bst_ff <= nxt_bst;
        bwr_ff <= nxt_bwr;
        bbank_ff <= nxt_bbank;
        bstart_ff <= nxt_bstart;
        bidx_ff <= nxt_bidx;
        blen_ff <= nxt_blen;
    end

    // read latency pipe, read data out, overflow flag
    always_comb begin
        nxt_pipe = pipe_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_dq = dq_ff;
        nxt_ovf = ovf_ff || (beat && !fifo_rdy);
        if (le && run) begin
            nxt_pipe = {pipe_ff[2:0], beat && !beat_wr};
            nxt_dq_oe = nxt_pipe[lat_idx];
            nxt_dq = rdat_i;
        end
        if (reset_i) begin
            nxt_pipe = '0;
            nxt_dq_oe = 1'b0;
            nxt_dq = '0;
            nxt_ovf = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        clk_d_ff <= reset_i ? 1'b0 : clk_s;
        pipe_ff <= nxt_pipe;
        dq_oe_ff <= nxt_dq_oe;
        dq_ff <= nxt_dq;
        ovf_ff <= nxt_ovf;
    end

    // beats go to storage through the fifo; full drops and flags
    assign push = beat && fifo_rdy;
    sdr_fifo #(.W(`SDR_ACC_W), .D(`SDR_ACC_DEPTH)) u_fifo (
        .clk_i(core_clk_i),
        .rst_i(reset_i),
        .in_valid_i(push),
        .in_ready_o(fifo_rdy),
        .in_data_i({beat_wr, beat_bank, beat_col, dq_s, hm_s, lm_s}),
        .out_valid_o(acc_valid_o),
        .out_ready_i(acc_ready_i),
        .out_data_o(acc_data_o)
    );

    assign dq_o = dq_ff;
    assign dq_oe_o = dq_oe_ff;
    assign bank0_state_o = bank_ff[0];
    assign bank1_state_o = bank_ff[1];
    assign mode_word_o = mode_ff;
    assign power_down_o = (pwr_ff == sdr_pkg::SDR_P_DOWN);
    assign self_refresh_o = (pwr_ff == sdr_pkg::SDR_P_SELF);
    assign overflow_o = ovf_ff;

    // checks
    sequence s_cmd_edge;
        le && run;
    endsequence
    property p_act_idle;
        @(posedge core_clk_i) disable iff (reset_i)
        s_cmd_edge ##0 (cmd == sdr_pkg::SDR_C_ACT && !bsel &&
        bank_ff[0] == sdr_pkg::SDR_B_IDLE) |=> bank_ff[0] == sdr_pkg::SDR_B_ACT;
    endproperty
    a_act_idle: assert property (p_act_idle) else $error("act failed");
    property p_pre_all;
        @(posedge core_clk_i) disable iff (reset_i)
        s_cmd_edge ##0 (cmd == sdr_pkg::SDR_C_PRE && addr_s[`SDR_A_AUTOPRE])
        |=> both_idle;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("pre all");
    property p_mode_load;
        @(posedge core_clk_i) disable iff (reset_i)
        s_cmd_edge ##0 (cmd == sdr_pkg::SDR_C_MODE && both_idle)
        |=> mode_ff == $past(addr_s);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode");
    property p_sleep_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        (pwr_ff != sdr_pkg::SDR_P_RUN) && !cke_s |=> $stable(mode_ff) &&
        both_idle;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep");
    property p_wake;
        @(posedge core_clk_i) disable iff (reset_i)
        (pwr_ff != sdr_pkg::SDR_P_RUN) && cke_s |=> pwr_ff == sdr_pkg::SDR_P_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake late");
    property p_rd_auto;
        @(posedge core_clk_i) disable iff (reset_i)
        rd_go && addr_s[`SDR_A_AUTOPRE] && len_rd != 9'h001 |=>
        bank_ff[$past(bsel)] == sdr_pkg::SDR_B_RDP;
    endproperty
    a_rd_auto: assert property (p_rd_auto) else $error("read auto");
    property p_wr_keep;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_go && !addr_s[`SDR_A_AUTOPRE] |=>
        bank_ff[$past(bsel)] inside {sdr_pkg::SDR_B_WR, sdr_pkg::SDR_B_ACT};
    endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("write keep");
    property p_lat2;
        @(posedge core_clk_i) disable iff (reset_i)
        le && run && pipe_ff[0] && mode_ff[`SDR_F_LAT] == `SDR_LAT_2
        |=> dq_oe_ff;
    endproperty
    a_lat2: assert property (p_lat2) else $error("latency");
    property p_wr_first;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_go |-> beat && beat_col == addr_s[`SDR_A_COL];
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("wr beat");
    property p_single;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_go && mode_ff[`SDR_F_WMODE] == `SDR_WM_SINGLE |=> !bst_ff;
    endproperty
    a_single: assert property (p_single) else $error("single");
endmodule

`default_nettype wire

// ===== dv/sdr_ctl_model.sv
// memory controller model driving the dram pins
`timescale 1ns/10ps
`default_nettype none

module sdr_ctl_model (
    output logic clk_o,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [11:0] addr_o,
    output logic lm_o,
    output logic hm_o,
    output logic [15:0] dq_o
);
    // link clock parked low, deselected, masks high
    initial begin
        clk_o = 1'b0;
        cke_o = 1'b1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
        addr_o = 12'h000;
        {lm_o, hm_o} = 2'h3;
        dq_o = 16'h0000;
    end

    // power-up hold before any command
    task automatic power_up();
        #100000;
        {lm_o, hm_o} = 2'h0;
    endtask

    // one command around a single link pulse; released pins flip
    task automatic issue(input logic [3:0] c, input logic [11:0] a,
                         input logic [15:0] d);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
        addr_o = a;
        dq_o = d;
        #62.5;
        clk_o = 1'b1;
        // pins flip well after the edge, never with the next command
        #31.25;
        addr_o = ~a;
        dq_o = ~d;
        #31.25;
        clk_o = 1'b0;
    endtask

    // clock enable level
    task automatic set_cke(input logic v);
        cke_o = v;
    endtask
endmodule

`default_nettype wire

// ===== dv/sdr_core_tb.sv
// self-checking bench for the dram command core
`timescale 1ns/10ps
`default_nettype none

module sdr_core_tb;
    logic clk, rst, sck, cke, cs_n, ras_n, cas_n, we_n, lm, hm, oe, rdy;
    logic av, pd, sr, ov;
    logic [11:0] a, mw;
    logic [15:0] dqi, dqo, rd;
    logic [27:0] ad;
    logic [5:0] b0, b1;
    logic [7:0] ilv [4] = '{8'h05, 8'h04, 8'h07, 8'h06};
    int error_cnt = 0;
    int checks_done = 0;
    localparam logic [3:0] NO_OPERATION_CMD = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
    localparam logic [3:0] PRE = 4'h2, REF = 4'h1, MODE_LOAD_CMD = 4'h0;
    localparam logic [27:0] ALL = 28'hfffffff, TOP = 28'hffc0000;

    sdr_ctl_model i_ctl (.clk_o(sck), .cke_o(cke), .cs_n_o(cs_n),
        .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .addr_o(a),
        .lm_o(lm), .hm_o(hm), .dq_o(dqi));
    sdr_core i_dut (.core_clk_i(clk), .reset_i(rst), .sd_clk_i(sck),
        .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
        .we_n_i(we_n), .addr_i(a), .low_byte_mask_i(lm),
        .high_byte_mask_i(hm), .dq_i(dqi), .dq_o(dqo), .dq_oe_o(oe),
        .rdat_i(rd), .acc_valid_o(av), .acc_ready_i(rdy), .acc_data_o(ad),
        .bank0_state_o(b0), .bank1_state_o(b1), .mode_word_o(mw),
        .power_down_o(pd), .self_refresh_o(sr), .overflow_o(ov));

    // core clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // compare one value and count it
    task automatic chk(input string n, input logic [27:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // both bank state vectors
    task automatic st(input logic [5:0] e0, e1);
        chk("bank0_state", 28'(e0), 28'(b0));
        chk("bank1_state", 28'(e1), 28'(b1));
    endtask

    // a command then nops, data counting up
    task automatic run(input logic [3:0] c, input logic [11:0] ca,
                       input int n, input logic [15:0] d);
        for (int i = 0; i < n; i++)
            i_ctl.issue(i == 0 ? c : NO_OPERATION_CMD, ca, d + 16'(i));
    endtask

    // take one access word from the fifo and compare it
    task automatic pop(input logic [27:0] e, m);
        @(negedge clk);
        for (int k = 0; k < 50 && av !== 1'b1; k++)
            @(negedge clk);
        chk("acc_valid", 28'h1, 28'(av));
        chk("acc_data", e & m, ad & m);
        rdy = 1'b1;
        @(negedge clk);
        rdy = 1'b0;
    endtask

    // watchdog well past the expected run length
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        rdy = 1'b0;
        rd = 16'h5a3c;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("mode_word", 28'h020, 28'(mw));
        st(6'h01, 6'h01);
        chk("flags", 28'h0, 28'({oe, av, pd, sr, ov}));
        i_ctl.power_up();
        run(PRE, 12'h400, 1, 16'h0);
        repeat (2) run(REF, 12'h000, 1, 16'h0);
        run(MODE_LOAD_CMD, 12'h021, 3, 16'h0);
        chk("mode_word", 28'h021, 28'(mw));
        run(RD, 12'h802, 1, 16'h0);
        st(6'h01, 6'h01);
        chk("acc_valid", 28'h0, 28'(av));
        run(ACT, 12'h8ab, 1, 16'h0);
        st(6'h01, 6'h02);
        run(WR, 12'hb05, 1, 16'h1111);
        st(6'h01, 6'h08);
        run(NO_OPERATION_CMD, 12'h000, 1, 16'h2222);
        st(6'h01, 6'h02);
        pop({2'h3, 8'h05, 16'h1111, 2'h0}, ALL);
        pop({2'h3, 8'h04, 16'h2222, 2'h0}, ALL);
        run(RD, 12'hc02, 2, 16'h0);
        chk("dq_oe", 28'h1, 28'(oe));
        chk("dq", 28'h5a3c, 28'(dqo));
        run(NO_OPERATION_CMD, 12'h000, 2, 16'h0);
        chk("dq_oe", 28'h0, 28'(oe));
        st(6'h01, 6'h01);
        pop({2'h1, 8'h02, 18'h0}, TOP);
        pop({2'h1, 8'h03, 18'h0}, TOP);
        run(MODE_LOAD_CMD, 12'h02a, 3, 16'h0);
        run(REF, 12'h000, 1, 16'h0);
        chk("mode_word", 28'h02a, 28'(mw));
        run(ACT, 12'h801, 1, 16'h0);
        run(WR, 12'hc05, 5, 16'h3000);
        st(6'h01, 6'h01);
        foreach (ilv[i])
            pop({2'h3, ilv[i], 16'h3000 + 16'(i), 2'h0}, ALL);
        run(MODE_LOAD_CMD, 12'h223, 3, 16'h0);
        run(ACT, 12'h011, 1, 16'h0);
        run(WR, 12'h010, 8, 16'h5000);
        pop({2'h2, 8'h10, 16'h5000, 2'h0}, ALL);
        chk("acc_valid", 28'h0, 28'(av));
        run(PRE, 12'h000, 1, 16'h0);
        st(6'h01, 6'h01);
        run(MODE_LOAD_CMD, 12'h023, 3, 16'h0);
        run(ACT, 12'h000, 1, 16'h0);
        run(WR, 12'h000, 8, 16'h4000);
        run(WR, 12'h000, 1, 16'h4100);
        chk("overflow", 28'h1, 28'(ov));
        for (int i = 0; i < 8; i++)
            pop({2'h2, 8'(i), 16'h4000 + 16'(i), 2'h0}, ALL);
        chk("acc_valid", 28'h0, 28'(av));
        run(ACT, 12'h800, 1, 16'h0);
        run(PRE, 12'h400, 1, 16'h0);
        st(6'h01, 6'h01);
        i_ctl.set_cke(1'b0);
        run(NO_OPERATION_CMD, 12'h000, 1, 16'h0);
        chk("power_down", 28'h1, 28'(pd));
        i_ctl.set_cke(1'b1);
        repeat (6) @(negedge clk);
        chk("power_down", 28'h0, 28'(pd));
        i_ctl.set_cke(1'b0);
        run(REF, 12'h000, 1, 16'h0);
        chk("self_refresh", 28'h1, 28'(sr));
        i_ctl.set_cke(1'b1);
        repeat (6) @(negedge clk);
        chk("self_refresh", 28'h0, 28'(sr));
        run(MODE_LOAD_CMD, 12'h030, 3, 16'h0);
        run(ACT, 12'h000, 1, 16'h0);
        run(RD, 12'h000, 2, 16'h0);
        chk("dq_oe", 28'h0, 28'(oe));
        run(NO_OPERATION_CMD, 12'h000, 1, 16'h0);
        chk("dq_oe", 28'h1, 28'(oe));
        stop_test();
    end
endmodule

`default_nettype wire
